// File: hw/uerx_buf.sv
`timescale 1ns/1ps

// Two-entry skid buffer; ready and valid are registered so that a stall
// downstream never costs a byte already offered by the serial engine.
module uerx_buf
(
  input wire logic clock,
  input wire logic rst_n,
  uerx_buf_if.buffer bif
);

  logic [7:0] mem [2];
  logic       rd_ptr;
  logic       wr_ptr;
  logic [1:0] cnt;
  logic [7:0] next_mem [2];
  logic       next_rd_ptr;
  logic       next_wr_ptr;
  logic [1:0] next_cnt;
  logic       in_ready;
  logic       out_valid;
  logic [7:0] out_data;
  logic       next_in_ready;
  logic       next_out_valid;
  logic [7:0] next_out_data;

  assign bif.in_ready  = in_ready;
  assign bif.out_valid = out_valid;
  assign bif.out_data  = out_data;

  always_comb
  begin
    logic push;
    logic pop;
    push        = 1'b0;
    pop         = 1'b0;
    next_mem    = mem;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_cnt    = cnt;
    if (bif.flush)
    begin
      next_rd_ptr = 1'b0;
      next_wr_ptr = 1'b0;
      next_cnt    = 2'h0;
    end
    else
    begin
      push = bif.in_valid && in_ready;
      pop  = out_valid && bif.out_ready;
      if (push)
      begin
        next_mem[wr_ptr] = bif.in_data;
        next_wr_ptr      = ~wr_ptr;
      end
      if (pop)
        next_rd_ptr = ~rd_ptr;
      if (push && !pop)
        next_cnt = cnt + 2'h1;
      else if (pop && !push)
        next_cnt = cnt - 2'h1;
    end
    next_in_ready  = (next_cnt != 2'h2);
    next_out_valid = (next_cnt != 2'h0);
    next_out_data  = next_mem[next_rd_ptr];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem[0]    <= 8'h00;
      mem[1]    <= 8'h00;
      rd_ptr    <= 1'b0;
      wr_ptr    <= 1'b0;
      cnt       <= 2'h0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= 8'h00;
    end
    else
    begin
      mem       <= next_mem;
      rd_ptr    <= next_rd_ptr;
      wr_ptr    <= next_wr_ptr;
      cnt       <= next_cnt;
      in_ready  <= next_in_ready;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
    end
  end

endmodule

// File: hw/uerx_buf_if.sv
`timescale 1ns/1ps

interface uerx_buf_if;
  logic       flush;
  logic       in_valid;
  logic       in_ready;
  logic [7:0] in_data;
  logic       out_valid;
  logic       out_ready;
  logic [7:0] out_data;

  modport ctrl
  (
    output flush,
    output in_valid,
    input  in_ready,
    output in_data,
    input  out_valid,
    output out_ready,
    input  out_data
  );

  modport buffer
  (
    input  flush,
    input  in_valid,
    output in_ready,
    input  in_data,
    output out_valid,
    input  out_ready,
    output out_data
  );
endinterface

// File: hw/uerx_ctrl.sv
// Notes on behaviour
// - Limit code 00 off, else 4/8/16
// - Warning flag when free bytes within limit
// - Flush empties FIFO, pointers, state idle
// - Flush waits while a reception runs
// - Ignore bit drops SETUP tokens for endpoint
// - Arm bit drops after packet or OUT stall
// - SETUP accepted whatever the arm bit
// - Back-to-back SETUP discarded but ACKed
// - Otherwise refused SETUP gets no handshake
// - Forced stall answers IN when transmit enabled
// - Forced stall answers OUT when receive enabled
// - Forced stall never answers a SETUP
// - Isochronous endpoint never sends NAK
// - Match endpoint number with function address
// - Disabled endpoint ignores every token
// - Endpoint number in bits three to zero
`timescale 1ns/1ps
`include "uerx_regs.svh"

module uerx_ctrl
(
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic [31:0]         bus_addr,
  input  wire logic                bus_wr,
  input  wire logic                bus_rd,
  input  wire logic [15:0]         bus_wdata,
  output logic [15:0]              bus_rdata,
  input  wire logic [6:0]          function_address,
  input  wire logic                tx_fifo_enable,
  input  wire logic                tok_valid,
  input  wire uerx_pkg::uerx_pid_t tok_pid,
  input  wire logic [6:0]          tok_addr,
  input  wire logic [3:0]          tok_ep,
  input  wire logic                rx_byte_valid,
  input  wire logic [7:0]          rx_byte,
  output logic                     rx_byte_ready,
  input  wire logic                rx_pkt_end,
  input  wire logic                rx_pkt_ok,
  output logic                     store_valid,
  output logic [7:0]               store_data,
  input  wire logic                store_ready,
  input  wire logic                fifo_pop,
  output logic                     hs_valid,
  output uerx_pkg::uerx_hs_t       hs_code,
  output logic                     rx_warning_flag,
  output logic                     rx_setup_flag,
  output logic                     rx_busy
);
  import uerx_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [6:0] warn_limit(input logic [1:0] code);
    case (code)
      2'h1:    warn_limit = `UERX_WL_CODE1;
      2'h2:    warn_limit = `UERX_WL_CODE2;
      2'h3:    warn_limit = `UERX_WL_CODE3;
      default: warn_limit = 7'h00;
    endcase
  endfunction

  uerx_buf_if bif ();

  uerx_buf u_buf
  (
    .clock (clock),
    .rst_n (rst_n),
    .bif   (bif.buffer)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  logic [1:0]  wl;
  logic        ign_setup;
  logic        arm;
  logic        flush_pend;
  logic [3:0]  ep_num;
  logic        ep_en;
  logic        iso;
  logic        stall;
  uerx_state_t state;
  logic        rx_is_setup;
  logic        last_setup;
  logic [6:0]  free_cnt;
  logic        flush_now;

  logic [1:0]  next_wl;
  logic        next_ign_setup;
  logic        next_arm;
  logic        next_flush_pend;
  logic [3:0]  next_ep_num;
  logic        next_ep_en;
  logic        next_iso;
  logic        next_stall;
  uerx_state_t next_state;
  logic        next_rx_is_setup;
  logic        next_last_setup;
  logic [6:0]  next_free_cnt;
  logic [15:0] next_bus_rdata;
  logic        next_hs_valid;
  uerx_hs_t    next_hs_code;
  logic        next_warn;
  logic        next_setup_flag;
  logic        next_flush_now;

  assign bif.flush      = flush_now;
  assign bif.in_valid   = rx_byte_valid && (state == UERX_ST_RECV);
  assign bif.in_data    = rx_byte;
  assign bif.out_ready  = store_ready;
  assign rx_byte_ready  = bif.in_ready;
  assign store_valid    = bif.out_valid;
  assign store_data     = bif.out_data;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    logic wr_rxc;
    logic wr_epc;
    logic match;
    logic stored;
    wr_rxc           = bus_wr && (bus_addr == `UERX_RXC_ADDR);
    wr_epc           = bus_wr && (bus_addr == `UERX_EPC_ADDR);
    match            = tok_valid && ep_en && (tok_ep == ep_num)
                       && (tok_addr == function_address);
    stored           = bif.out_valid && store_ready;
    next_wl          = wl;
    next_ign_setup   = ign_setup;
    next_arm         = arm;
    next_flush_pend  = flush_pend;
    next_ep_num      = ep_num;
    next_ep_en       = ep_en;
    next_iso         = iso;
    next_stall       = stall;
    next_state       = state;
    next_rx_is_setup = rx_is_setup;
    next_last_setup  = last_setup;
    next_free_cnt    = free_cnt;
    next_hs_valid    = 1'b0;
    next_hs_code     = UERX_HS_NONE;
    next_setup_flag  = 1'b0;
    next_flush_now   = 1'b0;
    next_bus_rdata   = bus_rdata;

    // Byte accounting of the receive FIFO behind the buffer
    if (stored && !fifo_pop && free_cnt != 7'h00)
      next_free_cnt = free_cnt - 7'h01;
    else if (fifo_pop && !stored && free_cnt != `UERX_FIFO_DEPTH)
      next_free_cnt = free_cnt + 7'h01;

    case (state)
      UERX_ST_IDLE:
      begin
        if (match)
        begin
          case (tok_pid)
            UERX_PID_SETUP:
            begin
              // Stall is not consulted here on purpose
              if (ign_setup)
                next_state = UERX_ST_IDLE;
              else if (last_setup)
              begin
                next_state       = UERX_ST_DISCARD;
                next_rx_is_setup = 1'b1;
              end
              else if (flush_pend || free_cnt == 7'h00)
              begin
                next_state       = UERX_ST_DISCARD;
                next_rx_is_setup = 1'b0;
              end
              else
              begin
                next_state       = UERX_ST_RECV;
                next_rx_is_setup = 1'b1;
              end
            end
            UERX_PID_OUT:
            begin
              next_last_setup = 1'b0;
              if (stall && arm)
              begin
                next_hs_valid = 1'b1;
                next_hs_code  = UERX_HS_STALL;
                next_arm      = 1'b0;
                next_state    = UERX_ST_DISCARD;
                next_rx_is_setup = 1'b0;
              end
              else if (!arm || free_cnt == 7'h00 || flush_pend)
              begin
                next_hs_valid    = !iso;
                next_hs_code     = UERX_HS_NAK;
                next_state       = UERX_ST_DISCARD;
                next_rx_is_setup = 1'b0;
              end
              else
              begin
                next_state       = UERX_ST_RECV;
                next_rx_is_setup = 1'b0;
              end
            end
            UERX_PID_IN:
            begin
              next_last_setup = 1'b0;
              if (stall && tx_fifo_enable)
              begin
                next_hs_valid = 1'b1;
                next_hs_code  = UERX_HS_STALL;
              end
            end
            default:
              next_last_setup = 1'b0;
          endcase
        end
      end
      UERX_ST_RECV:
      begin
        if (rx_pkt_end)
        begin
          next_state = UERX_ST_IDLE;
          if (rx_pkt_ok)
          begin
            next_hs_valid   = !iso;
            next_hs_code    = UERX_HS_ACK;
            next_arm        = 1'b0;
            next_last_setup = rx_is_setup;
            next_setup_flag = rx_is_setup;
          end
        end
      end
      UERX_ST_DISCARD:
      begin
        if (rx_pkt_end)
        begin
          next_state = UERX_ST_IDLE;
          if (rx_pkt_ok && rx_is_setup)
          begin
            next_hs_valid = 1'b1;
            next_hs_code  = UERX_HS_ACK;
          end
        end
      end
      default:
        next_state = UERX_ST_IDLE;
    endcase

    // Purge only once the engine no longer writes into the FIFO
    if (flush_pend && state != UERX_ST_RECV)
    begin
      next_flush_now  = 1'b1;
      next_flush_pend = 1'b0;
      next_state      = UERX_ST_IDLE;
      next_free_cnt   = `UERX_FIFO_DEPTH;
    end

    // Register writes; firmware arming beats the hardware drop
    if (wr_rxc)
    begin
      next_wl        = bus_wdata[`UERX_RXC_WL_HI:`UERX_RXC_WL_LO];
      next_ign_setup = bus_wdata[`UERX_RXC_IGN];
      next_arm       = bus_wdata[`UERX_RXC_ARM];
      if (bus_wdata[`UERX_RXC_FLUSH])
        next_flush_pend = 1'b1;
    end
    if (wr_epc)
    begin
      next_ep_num = bus_wdata[`UERX_EPC_EP_HI:`UERX_EPC_EP_LO];
      next_ep_en  = bus_wdata[`UERX_EPC_EN];
      next_iso    = bus_wdata[`UERX_EPC_ISO];
      next_stall  = bus_wdata[`UERX_EPC_STALL];
    end

    if (bus_rd)
    begin
      next_bus_rdata = 16'h0000;
      if (bus_addr == `UERX_RXC_ADDR)
      begin
        next_bus_rdata[`UERX_RXC_WL_HI:`UERX_RXC_WL_LO] = wl;
        next_bus_rdata[`UERX_RXC_FLUSH]                 = flush_pend;
        next_bus_rdata[`UERX_RXC_IGN]                   = ign_setup;
        next_bus_rdata[`UERX_RXC_ARM]                   = arm;
      end
      else if (bus_addr == `UERX_EPC_ADDR)
      begin
        next_bus_rdata[`UERX_EPC_EP_HI:`UERX_EPC_EP_LO] = ep_num;
        next_bus_rdata[`UERX_EPC_EN]                    = ep_en;
        next_bus_rdata[`UERX_EPC_ISO]                   = iso;
        next_bus_rdata[`UERX_EPC_STALL]                 = stall;
      end
    end

    // Limit 0 when disabled, so the compare is gated by the code
    next_warn = (wl != 2'h0) && (next_free_cnt <= warn_limit(wl));
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wl              <= 2'h0;
      ign_setup       <= 1'b0;
      arm             <= 1'b0;
      flush_pend      <= 1'b0;
      ep_num          <= 4'h0;
      ep_en           <= 1'b0;
      iso             <= 1'b0;
      stall           <= 1'b0;
      state           <= UERX_ST_IDLE;
      rx_is_setup     <= 1'b0;
      last_setup      <= 1'b0;
      free_cnt        <= `UERX_FIFO_DEPTH;
      flush_now       <= 1'b0;
      bus_rdata       <= 16'h0000;
      hs_valid        <= 1'b0;
      hs_code         <= UERX_HS_NONE;
      rx_warning_flag <= 1'b0;
      rx_setup_flag   <= 1'b0;
      rx_busy         <= 1'b0;
    end
    else
    begin
      wl              <= next_wl;
      ign_setup       <= next_ign_setup;
      arm             <= next_arm;
      flush_pend      <= next_flush_pend;
      ep_num          <= next_ep_num;
      ep_en           <= next_ep_en;
      iso             <= next_iso;
      stall           <= next_stall;
      state           <= next_state;
      rx_is_setup     <= next_rx_is_setup;
      last_setup      <= next_last_setup;
      free_cnt        <= next_free_cnt;
      flush_now       <= next_flush_now;
      bus_rdata       <= next_bus_rdata;
      hs_valid        <= next_hs_valid;
      hs_code         <= next_hs_code;
      rx_warning_flag <= next_warn;
      rx_setup_flag   <= next_setup_flag;
      rx_busy         <= (next_state == UERX_ST_RECV);
    end
  end

endmodule

// File: hw/uerx_pkg.sv
package uerx_pkg;

  typedef enum logic [1:0] {
    UERX_PID_OUT,
    UERX_PID_IN,
    UERX_PID_SETUP,
    UERX_PID_SOF
  } uerx_pid_t;

  typedef enum logic [1:0] {
    UERX_HS_ACK,
    UERX_HS_NAK,
    UERX_HS_STALL,
    UERX_HS_NONE
  } uerx_hs_t;

  typedef enum {
    UERX_ST_IDLE,
    UERX_ST_RECV,
    UERX_ST_DISCARD
  } uerx_state_t;

endpackage

// File: hw/uerx_regs.svh
`ifndef UERX_REGS_SVH
`define UERX_REGS_SVH

// Register addresses on the core bus
`define UERX_RXC_ADDR   32'h5000_185e
`define UERX_EPC_ADDR   32'h5000_1860

// Receive control fields
`define UERX_RXC_ARM    0
`define UERX_RXC_IGN    2
`define UERX_RXC_FLUSH  3
`define UERX_RXC_WL_LO  5
`define UERX_RXC_WL_HI  6

// Endpoint configuration fields
`define UERX_EPC_EP_LO  0
`define UERX_EPC_EP_HI  3
`define UERX_EPC_EN     4
`define UERX_EPC_ISO    5
`define UERX_EPC_STALL  7

// Reset values
`define UERX_RXC_RESET  16'h0000
`define UERX_EPC_RESET  16'h0000

// Receive FIFO size and warning thresholds (free bytes, inclusive)
`define UERX_FIFO_DEPTH 7'h40
`define UERX_WL_CODE1   7'h04
`define UERX_WL_CODE2   7'h08
`define UERX_WL_CODE3   7'h10

`endif

// File: verif/uerx_ctrl_bench.sv
`timescale 1ns/1ps
`include "uerx_regs.svh"

module uerx_ctrl_bench;
  import uerx_pkg::*;
  localparam logic [6:0] FA = 7'h2a;
  localparam logic [3:0] EP = 4'h5;
  logic        clock = 1'b0, rst_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, store_ready = 1'b1, fifo_pop = 1'b0;
  logic        tx_fifo_enable = 1'b0, tok_valid, rx_byte_valid, rx_byte_ready, rx_pkt_end, rx_pkt_ok;
  logic        store_valid, hs_valid, rx_warning_flag, rx_setup_flag, rx_busy;
  logic [31:0] bus_addr = 32'h0;
  logic [15:0] bus_wdata = 16'h0, bus_rdata, rv;
  logic [6:0]  function_address = FA, tok_addr;
  logic [3:0]  tok_ep;
  logic [7:0]  rx_byte, store_data;
  uerx_pid_t   tok_pid;
  uerx_hs_t    hs_code;
  int          err_count = 0, checked = 0;
  bit          late;
  logic        setup_seen;

  uerx_ctrl dut (.clock, .rst_n, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .function_address,
    .tx_fifo_enable, .tok_valid, .tok_pid, .tok_addr, .tok_ep, .rx_byte_valid, .rx_byte, .rx_byte_ready,
    .rx_pkt_end, .rx_pkt_ok, .store_valid, .store_data, .store_ready, .fifo_pop, .hs_valid, .hs_code,
    .rx_warning_flag, .rx_setup_flag, .rx_busy);
  uerx_host_model host (.clock, .rx_byte_ready, .tok_valid, .tok_pid, .tok_addr, .tok_ep, .rx_byte_valid,
    .rx_byte, .rx_pkt_end, .rx_pkt_ok);

  always #2 clock = ~clock;
  // ****************
  // Shared tasks
  // ****************
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task results;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wr(input logic [31:0] a, input logic [15:0] d);
    @(negedge clock);
    bus_addr  = a;
    bus_wdata = d;
    bus_wr    = 1'b1;
    @(negedge clock);
    bus_wr    = 1'b0;
  endtask
  task rd(input logic [31:0] a);
    @(negedge clock);
    bus_addr = a;
    bus_rd   = 1'b1;
    @(negedge clock);
    bus_rd   = 1'b0;
    @(negedge clock);
    rv       = bus_rdata;
  endtask
  task expect_hs(input uerx_hs_t exp);
    uerx_hs_t got;
    got = UERX_HS_NONE;
    setup_seen = 1'b0;
    for (int i = 0; i < 12 && got == UERX_HS_NONE; i++)
    begin
      if (hs_valid === 1'b1)
      begin
        got        = hs_code;
        setup_seen = rx_setup_flag;
      end
      @(negedge clock);
    end
    chk("handshake", 16'(got), 16'(exp));
  endtask
  // Early answers are awaited before the data phase; ACK only after it
  task pkt(input uerx_pid_t pid, input int n, input logic [6:0] a, input uerx_hs_t exp);
    host.send_token(pid, a, EP);
    if (exp != UERX_HS_ACK)
      expect_hs(exp);
    if (pid != UERX_PID_IN)
    begin
      host.send_bytes(n, 0, late);
      host.end_pkt(1'b1);
    end
    if (exp == UERX_HS_ACK)
      expect_hs(exp);
    bail;
  endtask
  // A byte stuck longer than the host allows ends the run
  task bail;
    if (late)
    begin
      err_count++;
      results();
    end
  endtask
  // ****************
  // Scenarios
  // ****************
  task s_regs;
    rd(`UERX_RXC_ADDR);
    chk("rxc reset", rv, `UERX_RXC_RESET);
    rd(`UERX_EPC_ADDR);
    chk("epc reset", rv, `UERX_EPC_RESET);
    wr(`UERX_EPC_ADDR, 16'hffff);
    rd(`UERX_EPC_ADDR);
    chk("epc fields", rv, 16'h00bf);
    wr(`UERX_RXC_ADDR, 16'hfff6);
    rd(`UERX_RXC_ADDR);
    chk("rxc fields", rv, 16'h0064);
    rd(32'h5000_1862);
    chk("unmapped", rv, 16'h0000);
    wr(`UERX_RXC_ADDR, 16'h0000);
    wr(`UERX_EPC_ADDR, 16'h0015);
  endtask
  task s_out;
    int w;
    wr(`UERX_RXC_ADDR, 16'h0001);
    store_ready = 1'b0;
    host.send_token(UERX_PID_OUT, FA, EP);
    fork
      host.send_bytes(6, 0, late);
      begin
        for (w = 0; w < 20 && rx_byte_ready !== 1'b0; w++)
          @(negedge clock);
        chk("buffer full", {15'h0, rx_byte_ready}, 16'h0000);
        chk("first stored byte", {7'h0, store_valid, store_data}, 16'h0110);
        repeat (3) @(negedge clock);
        store_ready = 1'b1;
      end
    join
    bail;
    host.end_pkt(1'b1);
    expect_hs(UERX_HS_ACK);
    rd(`UERX_RXC_ADDR);
    chk("arm after packet", {15'h0, rv[0]}, 16'h0000);
    pkt(UERX_PID_OUT, 2, FA, UERX_HS_NAK);
    wr(`UERX_RXC_ADDR, 16'h0001);
    pkt(UERX_PID_OUT, 2, FA, UERX_HS_ACK);
  endtask
  task s_stall;
    wr(`UERX_EPC_ADDR, 16'h0095);
    wr(`UERX_RXC_ADDR, 16'h0001);
    pkt(UERX_PID_OUT, 2, FA, UERX_HS_STALL);
    rd(`UERX_RXC_ADDR);
    chk("arm after stall", {15'h0, rv[0]}, 16'h0000);
    tx_fifo_enable = 1'b1;
    pkt(UERX_PID_IN, 0, FA, UERX_HS_STALL);
    pkt(UERX_PID_SETUP, 2, FA, UERX_HS_ACK);
    chk("setup taken", {15'h0, setup_seen}, 16'h0001);
    wr(`UERX_EPC_ADDR, 16'h0015);
  endtask
  task s_setup;
    pkt(UERX_PID_SETUP, 2, FA, UERX_HS_ACK);
    chk("setup discarded", {15'h0, setup_seen}, 16'h0000);
    wr(`UERX_RXC_ADDR, 16'h0004);
    pkt(UERX_PID_SETUP, 2, FA, UERX_HS_NONE);
  endtask
  task s_flush;
    wr(`UERX_RXC_ADDR, 16'h0001);
    host.send_token(UERX_PID_OUT, FA, EP);
    host.send_bytes(2, 1, late);
    bail;
    wr(`UERX_RXC_ADDR, 16'h0009);
    rd(`UERX_RXC_ADDR);
    chk("flush waits", {15'h0, rv[3]}, 16'h0001);
    host.end_pkt(1'b1);
    expect_hs(UERX_HS_ACK);
    repeat (3) @(negedge clock);
    rd(`UERX_RXC_ADDR);
    chk("flush done", {15'h0, rv[3]}, 16'h0000);
  endtask
  // Free space is counted from an empty FIFO after the flush
  task s_warn;
    logic [3:0] exp_flag;
    exp_flag = 4'b1100;
    wr(`UERX_RXC_ADDR, 16'h0001);
    pkt(UERX_PID_OUT, 59, FA, UERX_HS_ACK);
    for (int c = 0; c < 4; c++)
    begin
      wr(`UERX_RXC_ADDR, 16'(c) << 5);
      repeat (3) @(negedge clock);
      chk("warning five free", {15'h0, rx_warning_flag}, {15'h0, exp_flag[c]});
    end
    wr(`UERX_RXC_ADDR, 16'h0021);
    pkt(UERX_PID_OUT, 1, FA, UERX_HS_ACK);
    chk("warning four free", {15'h0, rx_warning_flag}, 16'h0001);
    wr(`UERX_RXC_ADDR, 16'h0021);
    pkt(UERX_PID_OUT, 4, FA, UERX_HS_ACK);
    wr(`UERX_RXC_ADDR, 16'h0000);
    repeat (2) @(negedge clock);
    chk("warning off when full", {15'h0, rx_warning_flag}, 16'h0000);
    pkt(UERX_PID_SETUP, 2, FA, UERX_HS_NONE);
    wr(`UERX_RXC_ADDR, 16'h0020);
    repeat (5)
    begin
      @(negedge clock);
      fifo_pop = 1'b1;
      @(negedge clock);
      fifo_pop = 1'b0;
    end
    repeat (3) @(negedge clock);
    chk("warning after pops", {15'h0, rx_warning_flag}, 16'h0000);
    wr(`UERX_RXC_ADDR, 16'h0008);
  endtask
  task s_quiet;
    wr(`UERX_RXC_ADDR, 16'h0000);
    wr(`UERX_EPC_ADDR, 16'h0035);
    pkt(UERX_PID_OUT, 2, FA, UERX_HS_NONE);
    wr(`UERX_EPC_ADDR, 16'h0015);
    pkt(UERX_PID_OUT, 2, FA ^ 7'h01, UERX_HS_NONE);
    wr(`UERX_EPC_ADDR, 16'h0005);
    pkt(UERX_PID_OUT, 2, FA, UERX_HS_NONE);
  endtask

  initial
  begin
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    s_regs;
    s_out;
    s_stall;
    s_setup;
    s_flush;
    s_warn;
    s_quiet;
    results;
  end
endmodule

// File: verif/uerx_ctrl_chk.sv
`timescale 1ns/1ps
`include "uerx_regs.svh"

module uerx_ctrl_chk
(
  input wire logic                clock,
  input wire logic                rst_n,
  input wire logic [31:0]         bus_addr,
  input wire logic                bus_wr,
  input wire logic                bus_rd,
  input wire logic [15:0]         bus_wdata,
  input wire logic [15:0]         bus_rdata,
  input wire logic [6:0]          function_address,
  input wire logic                tx_fifo_enable,
  input wire logic                tok_valid,
  input wire uerx_pkg::uerx_pid_t tok_pid,
  input wire logic [6:0]          tok_addr,
  input wire logic [3:0]          tok_ep,
  input wire logic                hs_valid,
  input wire uerx_pkg::uerx_hs_t  hs_code,
  input wire logic                rx_warning_flag,
  input wire logic                rx_busy
);
  import uerx_pkg::*;
  logic [7:0] epc;
  logic [1:0] wl;
  logic       ign;
  logic       hit;
  // ****************
  // Firmware-owned register shadows
  // ****************
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      epc <= 8'h00;
      wl  <= 2'h0;
      ign <= 1'b0;
    end
    else if (bus_wr && bus_addr == `UERX_EPC_ADDR)
      epc <= bus_wdata[7:0] & 8'hbf;
    else if (bus_wr && bus_addr == `UERX_RXC_ADDR)
    begin
      wl  <= bus_wdata[6:5];
      ign <= bus_wdata[2];
    end
  assign hit = tok_valid && !rx_busy && epc[4] && tok_ep == epc[3:0] && tok_addr == function_address;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ****************
  // Properties
  // ****************
  a_in_stall:
    assert property (hit && tok_pid == UERX_PID_IN && epc[7] && tx_fifo_enable
      |-> ##[1:2] (hs_valid && hs_code == UERX_HS_STALL)) else $error("IN token not stalled");
  a_setup_no_stall:
    assert property (tok_valid && tok_pid == UERX_PID_SETUP
      |-> ##1 (!(hs_valid && hs_code == UERX_HS_STALL))[*2]) else $error("SETUP answered with stall");
  a_iso_no_nak:
    assert property (hit && epc[5] |-> ##1 (!(hs_valid && hs_code == UERX_HS_NAK))[*2])
      else $error("NAK on isochronous endpoint");
  a_disabled_silent:
    assert property (tok_valid && !rx_busy && !epc[4] |-> ##1 (!hs_valid && !rx_busy)[*2])
      else $error("disabled endpoint responded");
  a_addr_miss:
    assert property (tok_valid && !rx_busy && epc[4] && (tok_ep != epc[3:0] || tok_addr != function_address)
      |-> ##1 (!hs_valid && !rx_busy)[*2]) else $error("foreign token taken");
  a_setup_ignored:
    assert property (hit && tok_pid == UERX_PID_SETUP && ign |-> ##1 (!hs_valid && !rx_busy)[*2])
      else $error("ignored SETUP taken");
  a_warn_off:
    assert property ((wl == 2'h0)[*2] |-> !rx_warning_flag) else $error("warning with limit off");
  a_epc_read:
    assert property ($past(bus_rd) && $past(bus_addr) == `UERX_EPC_ADDR |-> bus_rdata == {8'h00, epc})
      else $error("endpoint config readback wrong");
  a_rxc_reserved:
    assert property ($past(bus_rd) && $past(bus_addr) == `UERX_RXC_ADDR |-> bus_rdata[15:7] == 9'h000
      && bus_rdata[4] == 1'b0 && bus_rdata[1] == 1'b0 && bus_rdata[6:5] == wl && bus_rdata[2] == ign)
      else $error("receive control readback wrong");
  c_ack:   cover property (hs_valid && hs_code == UERX_HS_ACK);
  c_nak:   cover property (hs_valid && hs_code == UERX_HS_NAK);
  c_stall: cover property (hs_valid && hs_code == UERX_HS_STALL);
endmodule

bind uerx_ctrl uerx_ctrl_chk u_chk (.clock, .rst_n, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata,
  .function_address, .tx_fifo_enable, .tok_valid, .tok_pid, .tok_addr, .tok_ep, .hs_valid, .hs_code,
  .rx_warning_flag, .rx_busy);

// File: verif/uerx_host_model.sv
`timescale 1ns/1ps

// Host plus serial engine: tokens, payload bytes, packet end
module uerx_host_model
(
  input wire logic          clock,
  input wire logic          rx_byte_ready,
  output logic              tok_valid,
  output uerx_pkg::uerx_pid_t tok_pid,
  output logic [6:0]        tok_addr,
  output logic [3:0]        tok_ep,
  output logic              rx_byte_valid,
  output logic [7:0]        rx_byte,
  output logic              rx_pkt_end,
  output logic              rx_pkt_ok
);
  import uerx_pkg::*;
  initial
  begin
    tok_valid     = 1'b0;
    tok_pid       = UERX_PID_SOF;
    tok_addr      = 7'h00;
    tok_ep        = 4'h0;
    rx_byte_valid = 1'b0;
    rx_byte       = 8'h00;
    rx_pkt_end    = 1'b0;
    rx_pkt_ok     = 1'b0;
  end
  // Released fields flip so stale values never look valid
  task send_token(input uerx_pid_t pid, input logic [6:0] a, input logic [3:0] e);
    @(negedge clock);
    tok_valid = 1'b1;
    tok_pid   = pid;
    tok_addr  = a;
    tok_ep    = e;
    @(negedge clock);
    tok_valid = 1'b0;
    tok_pid   = uerx_pid_t'(~pid);
    tok_addr  = ~a;
    tok_ep    = ~e;
  endtask
  task send_bytes(input int n, input int gap, output bit late);
    int w;
    late = 1'b0;
    @(negedge clock);
    for (int i = 0; i < n; i++)
    begin
      rx_byte_valid = 1'b1;
      rx_byte       = 8'h10 + 8'(i);
      for (w = 0; w < 40 && rx_byte_ready !== 1'b1; w++)
        @(negedge clock);
      late = late | (w == 40);
      @(negedge clock);
      if (gap > 0)
      begin
        rx_byte_valid = 1'b0;
        repeat (gap) @(negedge clock);
      end
    end
    rx_byte_valid = 1'b0;
    rx_byte       = ~rx_byte;
  endtask
  task end_pkt(input logic ok);
    @(negedge clock);
    rx_pkt_end = 1'b1;
    rx_pkt_ok  = ok;
    @(negedge clock);
    rx_pkt_end = 1'b0;
    rx_pkt_ok  = ~ok;
  endtask
endmodule
